// ===== flash_self_program.sv
`timescale 1ns/10ps
`include "flash_seq_defs.svh"

// Function
// - read uses the second cycle after trigger; that instruction is discarded.
// - fetched word lands in the data pair the next cycle.
// - data pair holds until another read or a software write.
// - erase, latch load and commits start only after an unbroken key sequence.
// - once write trigger sets, next two slots are forced nops.
// - row erase or program stalls execution for up to about 2 ms, or until write_done, then resumes.
// - latch load inserts two forced nops and continues without stall.
// - erase always covers a whole row, never single words.
// - two setup cycles after erase trigger; resume at third instruction.
// - erase halt stops only instructions; clocks and peripherals keep running.
// - triggers are set-only by software, cleared by hardware on completion.
// - write allow clear at power-up; abort flag set if reset breaks a write.
// - key port is write-only and reads as zero.
// - data pair is 14 bits, address pair is 15 bits.
module flash_self_program #(
    parameter int ERASE_CYCLES = (`ERASE_TIME_US * `CLK_MHZ)
) (
    input  wire logic                       clk,
    input  wire logic                       rst,
    input  wire flash_seq_pkg::cpu_req_t    cpu_req,
    input  wire logic                       irq_taken,
    input  wire logic                       write_done,
    input  wire logic [`DATA_W-1:0]         array_rdata,
    output logic [`ADDR_W-1:0]              prog_addr,
    output logic [`DATA_W-1:0]              prog_data,
    output logic [7:0]                      key_port_rdata,
    output logic                            read_busy,
    output logic                            write_busy,
    output logic                            erase_sel,
    output logic                            latch_only,
    output logic                            config_space_select,
    output logic                            write_allow,
    output logic                            write_abort_flag,
    output logic                            force_nop,
    output logic                            cpu_stall,
    output logic                            array_read,
    output logic                            array_erase_row,
    output logic                            array_load_latch,
    output logic                            array_program_row,
    output flash_seq_pkg::array_req_t       array_req
);
    import flash_seq_pkg::*;

    seq_state_t         state;
    seq_state_t         next_state;
    key_state_t         key;
    logic [1:0]         slot;
    logic [31:0]        stall_cnt;
    logic               op_erase;
    logic               op_load;

    // write trigger accepted only after both keys and with writes allowed
    wire trigger_ok  = cpu_req.set_write && key == key_two && write_allow
                       && !config_space_select && state == st_idle;
    wire read_start  = cpu_req.set_read && state == st_idle;
    wire key_break   = irq_taken || (cpu_req.we_key && key == key_two)
                       || (cpu_req.we_key && key == key_one && cpu_req.data != `KEY_SECOND)
                       || (key != key_none && !cpu_req.we_key && cpu_req.set_write
                           && !trigger_ok);
    wire slots_done  = slot == `FORCED_SLOTS - 2'h1;
    wire stall_done  = stall_cnt == 32'(ERASE_CYCLES - 1) || write_done;
    wire [`ADDR_W-1:0] row_base = {prog_addr[`ADDR_W-1:`ROW_OFFS_W], {`ROW_OFFS_W{1'b0}}};

    always_comb begin
        next_state = state;
        case (state)
            st_idle:    if (read_start) next_state = st_rd_wait;
                        else if (trigger_ok) next_state = st_wr_nop;
            st_rd_wait: next_state = st_rd_slot;
            st_rd_slot: next_state = st_idle;
            st_wr_nop:  if (slots_done) next_state = op_load ? st_idle : st_stall;
            st_stall:   if (stall_done) next_state = st_idle;
            default:    next_state = st_idle;
        endcase
    end

    assign key_port_rdata    = 8'h00;
    assign read_busy         = state == st_rd_wait || state == st_rd_slot;
    assign write_busy        = state == st_wr_nop || state == st_stall;
    assign force_nop         = state == st_wr_nop || state == st_rd_slot;
    assign cpu_stall         = state == st_stall;
    assign array_read        = state == st_rd_wait;
    assign array_load_latch  = state == st_wr_nop && slots_done && op_load;
    assign array_erase_row   = state == st_stall && stall_cnt == 32'h0 && op_erase;
    assign array_program_row = state == st_stall && stall_cnt == 32'h0 && !op_erase;
    // row base only while an erase owns the array; reads use the full address
    assign array_req.addr    = (op_erase && write_busy) ? row_base : prog_addr;
    assign array_req.wdata   = prog_data;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state <= st_idle;
            key   <= key_none;
        end else begin
            state <= next_state;
            if (key_break || trigger_ok)
                key <= key_none;
            else if (cpu_req.we_key && cpu_req.data == `KEY_FIRST && key == key_none)
                key <= key_one;
            else if (cpu_req.we_key && key == key_one)
                key <= key_two;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            slot      <= 2'h0;
            stall_cnt <= 32'h0;
            op_erase  <= 1'b0;
            op_load   <= 1'b0;
        end else begin
            slot      <= (state == st_wr_nop) ? slot + 2'h1 : 2'h0;
            stall_cnt <= (state == st_stall) ? stall_cnt + 32'h1 : 32'h0;
            if (trigger_ok) begin
                op_erase <= erase_sel;
                op_load  <= latch_only && !erase_sel;
            end
        end
    end

    // control bits; abort flag is the only one reset leaves set
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            erase_sel           <= 1'b0;
            latch_only          <= 1'b0;
            config_space_select <= 1'b0;
            write_allow         <= 1'b0;
        end else begin
            if (cpu_req.set_erase_sel) erase_sel <= 1'b1;
            else if (cpu_req.clr_erase_sel) erase_sel <= 1'b0;
            if (cpu_req.set_latch_only) latch_only <= 1'b1;
            else if (cpu_req.clr_latch_only) latch_only <= 1'b0;
            if (cpu_req.set_cfg_sel) config_space_select <= 1'b1;
            else if (cpu_req.clr_cfg_sel) config_space_select <= 1'b0;
            if (cpu_req.set_write_allow) write_allow <= 1'b1;
            else if (cpu_req.clr_write_allow) write_allow <= 1'b0;
        end
    end

    // abort flag: clear at power-up, survives reset, set when reset hits a live write
    // cleared by the next accepted write trigger; the set wins over the clear
    logic write_active = 1'b0;
    logic abort_seen   = 1'b0;
    always_ff @(posedge clk) begin
        write_active <= !rst && write_busy;
        if (rst && write_active)
            abort_seen <= 1'b1;
        else if (trigger_ok)
            abort_seen <= 1'b0;
    end
    assign write_abort_flag = abort_seen;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            prog_addr <= '0;
            prog_data <= '0;
        end else begin
            if (cpu_req.we_addr_low)  prog_addr[7:0] <= cpu_req.data;
            if (cpu_req.we_addr_high) prog_addr[`ADDR_W-1:8] <= cpu_req.data[6:0];
            if (state == st_rd_wait)
                prog_data <= array_rdata;
            else begin
                if (cpu_req.we_data_low)  prog_data[7:0] <= cpu_req.data;
                if (cpu_req.we_data_high) prog_data[`DATA_W-1:8] <= cpu_req.data[5:0];
            end
        end
    end

    a_read_slot_nop: assert property (@(posedge clk) disable iff (rst)
        read_start |=> array_read ##1 force_nop ##1 !read_busy) else $error("read slot timing wrong");
    a_read_data_lands: assert property (@(posedge clk) disable iff (rst)
        array_read |=> prog_data == $past(array_rdata)) else $error("read data not loaded");
    a_data_holds: assert property (@(posedge clk) disable iff (rst)
        (!array_read && !cpu_req.we_data_low && !cpu_req.we_data_high) |=> $stable(prog_data))
        else $error("data pair changed");
    a_no_unarmed_write: assert property (@(posedge clk) disable iff (rst)
        (cpu_req.set_write && !write_allow && state == st_idle) |=> state == st_idle)
        else $error("write started without allow");
    a_forced_two_nops: assert property (@(posedge clk) disable iff (rst)
        trigger_ok |=> force_nop [*2]) else $error("two forced nops missing");
    a_load_no_stall: assert property (@(posedge clk) disable iff (rst)
        (trigger_ok && latch_only && !erase_sel) |=> ##2 !cpu_stall) else $error("latch load stalled");
    a_erase_stalls: assert property (@(posedge clk) disable iff (rst)
        (trigger_ok && erase_sel) |=> ##2 cpu_stall && array_erase_row) else $error("erase stall missing");
    a_key_port_zero: assert property (@(posedge clk) disable iff (rst)
        key_port_rdata == 8'h00) else $error("key port readable");

    // key sequence and config-space write guards
    a_irq_breaks_keys: assert property (@(posedge clk) disable iff (rst)
        irq_taken |=> key == key_none)
        else $error("key sequence survived interrupt");
    a_wrong_key_breaks: assert property (@(posedge clk) disable iff (rst)
        (cpu_req.we_key && key == key_one && cpu_req.data != `KEY_SECOND) |=> key == key_none)
        else $error("wrong second key accepted");
    a_cfg_blocks_write: assert property (@(posedge clk) disable iff (rst)
        (cpu_req.set_write && config_space_select && state == st_idle) |=> !write_busy)
        else $error("write started in config space");

    // erase and stall shape, read trigger clear
    a_erase_row_aligned: assert property (@(posedge clk) disable iff (rst)
        array_erase_row |-> array_req.addr[`ROW_OFFS_W-1:0] == '0)
        else $error("erase address not row aligned");
    a_erase_setup_nops: assert property (@(posedge clk) disable iff (rst)
        (trigger_ok && erase_sel) |=> force_nop && !cpu_stall ##1 force_nop && !cpu_stall ##1 cpu_stall)
        else $error("erase setup slots wrong");
    a_stall_bounded: assert property (@(posedge clk) disable iff (rst)
        cpu_stall |-> stall_cnt < 32'(ERASE_CYCLES))
        else $error("stall ran past erase time");
    a_stall_ends_idle: assert property (@(posedge clk) disable iff (rst)
        (state == st_stall && stall_done) |=> !write_busy && !cpu_stall)
        else $error("write trigger not cleared");
    a_read_self_clears: assert property (@(posedge clk) disable iff (rst)
        state == st_rd_slot |=> !read_busy)
        else $error("read trigger not cleared");

endmodule : flash_self_program

// ===== flash_seq_defs.svh
`ifndef FLASH_SEQ_DEFS_SVH
`define FLASH_SEQ_DEFS_SVH

`define KEY_FIRST        8'h55
`define KEY_SECOND       8'haa
`define DATA_W           14
`define ADDR_W           15
`define ROW_OFFS_W       5
`define FORCED_SLOTS     2'h2
`define ERASE_TIME_US    2000
`define CLK_MHZ          125
`define BLANK_WORD       14'h3fff

`endif

// ===== flash_seq_pkg.sv
`include "flash_seq_defs.svh"

package flash_seq_pkg;

    typedef struct packed {
        logic [7:0] data;
        logic       we_addr_low;
        logic       we_addr_high;
        logic       we_data_low;
        logic       we_data_high;
        logic       we_key;
        logic       set_read;
        logic       set_write;
        logic       set_erase_sel;
        logic       set_latch_only;
        logic       set_cfg_sel;
        logic       set_write_allow;
        logic       clr_erase_sel;
        logic       clr_latch_only;
        logic       clr_cfg_sel;
        logic       clr_write_allow;
    } cpu_req_t;

    typedef struct packed {
        logic [`ADDR_W-1:0] addr;
        logic [`DATA_W-1:0] wdata;
    } array_req_t;

    typedef enum logic [2:0] {
        st_idle    = 3'b000,
        st_rd_wait = 3'b001,
        st_rd_slot = 3'b010,
        st_wr_nop  = 3'b011,
        st_stall   = 3'b100
    } seq_state_t;

    typedef enum logic [1:0] {
        key_none = 2'b00,
        key_one  = 2'b01,
        key_two  = 2'b10
    } key_state_t;

endpackage : flash_seq_pkg

// ===== flash_array_model.sv
`timescale 1ns/10ps
`include "flash_seq_defs.svh"
module flash_array_model (
    input  wire logic                      clk,
    input  wire logic                      array_read,
    input  wire logic                      array_erase_row,
    input  wire logic                      array_program_row,
    input  wire flash_seq_pkg::array_req_t array_req,
    input  wire logic                      prompt,
    output logic                           write_done,
    output logic [`DATA_W-1:0]             array_rdata
);
    import flash_seq_pkg::*;
    logic [`DATA_W-1:0] junk = 14'h0000;
    logic [2:0]         left = 3'h0;
    // stored word follows the address; a changing pattern outside read cycles
    assign array_rdata = array_read ? (array_req.addr[`DATA_W-1:0] ^ 14'h1234) : junk;
    assign write_done  = (left == 3'h1);
    always @(posedge clk) begin
        junk <= ~junk ^ 14'h0001;
        if ((array_erase_row || array_program_row) && prompt)
            left <= 3'h5;
        else if (left != 3'h0)
            left <= left - 3'h1;
    end
endmodule : flash_array_model

// ===== test_flash_self_program.sv
`timescale 1ns/10ps
`include "flash_seq_defs.svh"
module test_flash_self_program;
    import flash_seq_pkg::*;
    localparam int erase_cycles = 20;
    localparam logic [14:0] f_al = 15'h4000, f_ah = 15'h2000, f_dl = 15'h1000, f_dh = 15'h0800,
        f_key = 15'h0400, f_rd = 15'h0200, f_wr = 15'h0100, f_es = 15'h0080, f_lo = 15'h0040,
        f_cfg = 15'h0020, f_wa = 15'h0010, f_ces = 15'h0008, f_clo = 15'h0004, f_ccfg = 15'h0002,
        f_cwa = 15'h0001;
    logic clk = 1'b0, rst = 1'b1, irq_taken = 1'b0, prompt = 1'b0;
    logic write_done, read_busy, write_busy, erase_sel, latch_only, config_space_select, write_allow;
    logic write_abort_flag, force_nop, cpu_stall, array_read, array_erase_row, array_load_latch;
    logic array_program_row;
    logic [`DATA_W-1:0] array_rdata, prog_data, last_wdata;
    logic [`ADDR_W-1:0] prog_addr, last_addr;
    logic [7:0]         key_port_rdata;
    cpu_req_t           cpu_req = '0;
    array_req_t         array_req;
    int failures = 0, total_checks = 0, n_erase = 0, n_load = 0, n_prog = 0, stall_cnt = 0;
    flash_self_program #(.ERASE_CYCLES(erase_cycles)) dut (.clk(clk), .rst(rst), .cpu_req(cpu_req),
        .irq_taken(irq_taken), .write_done(write_done), .array_rdata(array_rdata),
        .prog_addr(prog_addr), .prog_data(prog_data), .key_port_rdata(key_port_rdata),
        .read_busy(read_busy), .write_busy(write_busy), .erase_sel(erase_sel), .latch_only(latch_only),
        .config_space_select(config_space_select), .write_allow(write_allow),
        .write_abort_flag(write_abort_flag), .force_nop(force_nop), .cpu_stall(cpu_stall),
        .array_read(array_read), .array_erase_row(array_erase_row), .array_load_latch(array_load_latch),
        .array_program_row(array_program_row), .array_req(array_req));
    flash_array_model far (.clk(clk), .array_read(array_read), .array_erase_row(array_erase_row),
        .array_program_row(array_program_row), .array_req(array_req), .prompt(prompt),
        .write_done(write_done), .array_rdata(array_rdata));
    initial forever #4 clk = ~clk;
    always @(posedge clk) begin
        n_erase   <= n_erase + int'(array_erase_row);
        n_load    <= n_load + int'(array_load_latch);
        n_prog    <= n_prog + int'(array_program_row);
        stall_cnt <= stall_cnt + int'(cpu_stall);
        if (array_erase_row || array_load_latch)
            last_addr <= array_req.addr;
        if (array_load_latch)
            last_wdata <= array_req.wdata;
    end
    task automatic chk_v(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp) begin
            failures++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk_v
    task automatic chk_b(input logic got, input logic exp);
        chk_v({15'h0000, got}, {15'h0000, exp});
    endtask : chk_b
    task automatic conclude();
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : conclude
    task automatic send(input logic [14:0] f, input logic [7:0] d);
        @(negedge clk);
        cpu_req = {d, f};
        @(negedge clk);
        cpu_req = '0;
    endtask : send
    task automatic arm(input logic [7:0] k2);
        send(f_key, 8'h55);
        send(f_key, k2);
        send(f_wr, 8'h00);
    endtask : arm
    task automatic wait_idle();
        for (int i = 0; i < 200 && write_busy !== 1'b0; i++)
            @(negedge clk);
        if (write_busy !== 1'b0) begin
            failures++;
            conclude();
        end
    endtask : wait_idle
    task automatic write_op(input int stall_exp, input int erase_exp, input int load_exp, input int prog_exp);
        stall_cnt = 0;
        arm(8'haa);
        chk_b(force_nop, 1'b1);
        chk_b(write_busy, 1'b1);
        @(negedge clk);
        chk_b(force_nop, 1'b1);
        wait_idle();
        repeat (2) @(negedge clk);
        if (stall_exp < 0)
            chk_b(stall_cnt > 0 && stall_cnt < erase_cycles, 1'b1);
        else
            chk_v(16'(stall_cnt), 16'(stall_exp));
        chk_v(16'(n_erase * 64 + n_load * 8 + n_prog), 16'(erase_exp * 64 + load_exp * 8 + prog_exp));
    endtask : write_op
    initial begin
        repeat (2) @(negedge clk);
        rst = 1'b0;
        chk_b(write_allow, 1'b0);
        chk_b(write_abort_flag, 1'b0);
        chk_v(16'(key_port_rdata), 16'h0000);
        send(f_al, 8'h45);
        send(f_ah, 8'h92);
        send(f_ccfg, 8'h00);
        chk_v(16'(prog_addr), 16'h1245);
        send(f_rd, 8'h00);
        chk_b(array_read, 1'b1);
        chk_b(read_busy, 1'b1);
        @(negedge clk);
        chk_b(force_nop, 1'b1);
        chk_v(16'(prog_data), 16'h1245 ^ 16'h1234);
        repeat (4) @(negedge clk);
        chk_b(read_busy, 1'b0);
        chk_v(16'(prog_data), 16'h1245 ^ 16'h1234);
        send(f_dl, 8'h5a);
        send(f_dh, 8'hff);
        chk_v(16'(prog_data), 16'h3f5a);
        send(f_wa, 8'h00);
        send(f_es, 8'h00);
        chk_b(erase_sel, 1'b1);
        send(f_wr, 8'h00);
        send(f_key, 8'h55);
        irq_taken = 1'b1;
        @(negedge clk);
        irq_taken = 1'b0;
        send(f_key, 8'haa);
        send(f_wr, 8'h00);
        arm(8'ha5);
        send(f_cwa, 8'h00);
        arm(8'haa);
        repeat (3) @(negedge clk);
        chk_v(16'(n_erase + stall_cnt), 16'h0000);
        chk_b(write_busy, 1'b0);
        send(f_wa, 8'h00);
        write_op(erase_cycles, 1, 0, 0);
        chk_v(16'(last_addr), 16'h1240);
        prompt = 1'b1;
        write_op(-1, 2, 0, 0);
        send(f_ces, 8'h00);
        chk_b(erase_sel, 1'b0);
        send(f_lo, 8'h00);
        chk_b(latch_only, 1'b1);
        write_op(0, 2, 1, 0);
        chk_v(16'(last_addr), 16'h1245);
        chk_v(16'(last_wdata), 16'h3f5a);
        send(f_clo, 8'h00);
        chk_b(latch_only, 1'b0);
        write_op(-1, 2, 1, 1);
        send(f_cfg, 8'h00);
        chk_b(config_space_select, 1'b1);
        arm(8'haa);
        chk_b(write_busy, 1'b0);
        send(f_ccfg, 8'h00);
        chk_b(config_space_select, 1'b0);
        prompt = 1'b0;
        arm(8'haa);
        repeat (6) @(negedge clk);
        rst = 1'b1;
        @(negedge clk);
        rst = 1'b0;
        chk_b(write_abort_flag, 1'b1);
        chk_b(write_allow, 1'b0);
        conclude();
    end
endmodule : test_flash_self_program
